// ===== hw/trace_seq_consts.vh
// constants for the trace capture and trigger sequencer
`ifndef TRACE_SEQ_CONSTS_VH
`define TRACE_SEQ_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define A_CTRL      8'h00
`define A_STATUS    8'h04
`define A_SEL       8'h08
`define A_PAT       8'h0c
`define A_MASK      8'h10
`define A_OCC       8'h14
`define A_RDADDR    8'h18
`define A_RDDATA    8'h1c
`define A_RDINFO    8'h20

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_START  0
`define CTRL_STOP   1
`define CTRL_CMODE  2
`define CTRL_UNTIL  4
`define CTRL_BRK    5
`define CTRL_WIN    6
`define CTRL_FGMON  7
`define CTRL_NTERM  8
`define CTRL_RESET  32'h0000_0100
`define CTRL_WMASK  32'h0000_07fc

// ----------------------------------------------------------------------
// count qualifier modes and depths
// ----------------------------------------------------------------------
`define CMODE_TIME  2'h0
`define CMODE_STATE 2'h1
`define CMODE_OFF   2'h2
`define DEPTH_CNT   11'h200
`define DEPTH_NOCNT 11'h400

// ----------------------------------------------------------------------
// sequencer slots and limits
// ----------------------------------------------------------------------
`define MAX_TERMS   3'h7
`define WIN_TERMS   3'h4
`define SLOT_RST    4'h7
`define SLOT_CNTQ   4'h8
`define NUM_SLOTS   9
`define OCC_RESET   16'h0001

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== hw/state_fifo.v
// small synchronous fifo between the bus-state stream and capture logic
`timescale 1ns/1ps
module state_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,
    input  wire             rstn,
    input  wire             inValid,
    input  wire [WIDTH-1:0] inData,
    output wire             inReady,
    output wire             outValid,
    output wire [WIDTH-1:0] outData,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr_q;
    reg [AW:0]      rdPtr_q;
    wire            empty;
    wire            full;

    assign empty    = (wrPtr_q == rdPtr_q);
    assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) &&
                      (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem[rdPtr_q[AW-1:0]];

    always @(posedge clk_sys) begin
        if (inValid && !full)
            mem[wrPtr_q[AW-1:0]] <= inData;
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            wrPtr_q <= {(AW+1){1'b0}};
            rdPtr_q <= {(AW+1){1'b0}};
        end else begin
            if (inValid && !full)
                wrPtr_q <= wrPtr_q + 1'b1;
            if (outReady && !empty)
                rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
endmodule // state_fifo

// ===== hw/trace_mem.v
// trace memory: one write port, registered read port
`timescale 1ns/1ps
module trace_mem #(
    parameter WIDTH = 50,
    parameter AW    = 10
) (
    input  wire             clk_sys,
    input  wire             we,
    input  wire [AW-1:0]    waddr,
    input  wire [WIDTH-1:0] wdata,
    input  wire [AW-1:0]    raddr,
    output reg  [WIDTH-1:0] rdata
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk_sys) begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule // trace_mem

// ===== hw/trace_trigger_sequencer.v
// trace capture, count qualifier and trigger sequencer with axi4-lite
`timescale 1ns/1ps
`include "trace_seq_consts.vh"
module trace_trigger_sequencer #(
    parameter STATE_W = 32
) (
    input  wire               clk_sys,
    input  wire               rstn,
    input  wire [7:0]         awaddr,
    input  wire               awvalid,
    output wire               awready,
    input  wire [31:0]        wdata,
    input  wire [3:0]         wstrb,
    input  wire               wvalid,
    output wire               wready,
    output reg  [1:0]         bresp,
    output reg                bvalid,
    input  wire               bready,
    input  wire [7:0]         araddr,
    input  wire               arvalid,
    output wire               arready,
    output reg  [31:0]        rdata,
    output reg  [1:0]         rresp,
    output reg                rvalid,
    input  wire               rready,
    input  wire               stateValid,
    input  wire [STATE_W-1:0] stateData,
    output wire               stateReady,
    input  wire               procHalted,
    input  wire               inMonitor,
    output reg                breakReq,
    output reg                triggered,
    output reg                running
);
    localparam MW = STATE_W + 18;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function hit;
        input [STATE_W-1:0] d;
        input [31:0]        p;
        input [31:0]        m;
        begin
            hit = (((d ^ p[STATE_W-1:0]) & m[STATE_W-1:0]) == 0);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    merge[8*b +: 8] = nw[8*b +: 8];
        end
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    reg haltM_q, haltS_q, monM_q, monS_q;
    always @(posedge clk_sys) begin
        if (!rstn) begin
            haltM_q <= 1'b0;
            haltS_q <= 1'b0;
            monM_q  <= 1'b0;
            monS_q  <= 1'b0;
        end else begin
            haltM_q <= procHalted;
            haltS_q <= haltM_q;
            monM_q  <= inMonitor;
            monS_q  <= monM_q;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    reg        awHeld_q, wHeld_q;
    reg [7:0]  awAddr_q;
    reg [31:0] wData_q;
    reg [3:0]  wStrb_q;
    reg [31:0] ctrl_q;
    reg [3:0]  sel_q;
    reg [9:0]  rdAddr_q;
    reg [31:0] pat_q  [0:`NUM_SLOTS-1];
    reg [31:0] mask_q [0:`NUM_SLOTS-1];
    reg [15:0] occ_q  [0:6];
    reg        startP_q, stopP_q;
    wire       wrFire;
    wire [31:0] occWr;
    wire [31:0] rdaWr;
    reg        wrOk;
    integer    i;

    assign awready = !awHeld_q && !bvalid;
    assign wready  = !wHeld_q && !bvalid;
    assign wrFire  = awHeld_q && wHeld_q && !bvalid;
    assign occWr   = merge({16'h0000, occ_q[sel_q[2:0]]}, wData_q, wStrb_q);
    assign rdaWr   = merge({22'h000000, rdAddr_q}, wData_q, wStrb_q);

    always @* begin
        case (awAddr_q)
            `A_CTRL, `A_SEL, `A_PAT,
            `A_MASK, `A_OCC, `A_RDADDR: wrOk = 1'b1;
            default:                    wrOk = 1'b0;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= `RESP_OKAY;
            ctrl_q   <= `CTRL_RESET;
            sel_q    <= 4'h0;
            rdAddr_q <= 10'h000;
            startP_q <= 1'b0;
            stopP_q  <= 1'b0;
            for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
                pat_q[i]  <= 32'h0000_0000;
                mask_q[i] <= 32'h0000_0000;
            end
            for (i = 0; i < 7; i = i + 1)
                occ_q[i] <= `OCC_RESET;
        end else begin
            startP_q <= 1'b0;
            stopP_q  <= 1'b0;
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (bvalid && bready)
                bvalid <= 1'b0;
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
                case (awAddr_q)
                    `A_CTRL: begin
                        // start and stop are self-clearing commands
                        ctrl_q <= merge(ctrl_q, wData_q, wStrb_q)
                                  & `CTRL_WMASK;
                        startP_q <= wStrb_q[0] && wData_q[`CTRL_START];
                        stopP_q  <= wStrb_q[0] && wData_q[`CTRL_STOP];
                    end
                    `A_SEL:
                        if (wStrb_q[0])
                            sel_q <= wData_q[3:0];
                    `A_PAT:
                        if (sel_q <= `SLOT_CNTQ)
                            pat_q[sel_q] <= merge(pat_q[sel_q], wData_q,
                                                  wStrb_q);
                    `A_MASK:
                        if (sel_q <= `SLOT_CNTQ)
                            mask_q[sel_q] <= merge(mask_q[sel_q], wData_q,
                                                   wStrb_q);
                    `A_OCC:
                        if (sel_q < `SLOT_RST)
                            occ_q[sel_q[2:0]] <= occWr[15:0];
                    `A_RDADDR:
                        rdAddr_q <= rdaWr[9:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // capture engine
    // ------------------------------------------------------------------
    wire [1:0]         cmode   = ctrl_q[`CTRL_CMODE +: 2];
    wire               untilH  = ctrl_q[`CTRL_UNTIL];
    wire               brkOn   = ctrl_q[`CTRL_BRK];
    wire               win     = ctrl_q[`CTRL_WIN];
    wire               fgMon   = ctrl_q[`CTRL_FGMON];
    wire [2:0]         nReq    = ctrl_q[`CTRL_NTERM +: 3];
    wire               fifoVal;
    wire [STATE_W-1:0] fifoDat;
    wire [MW-1:0]      memOut;
    reg  [2:0]         idx_q;
    reg  [15:0]        occCnt_q;
    reg  [15:0]        count_q;
    reg  [10:0]        wrPtr_q;
    reg  [2:0]         nTerms;
    reg  [15:0]        occNeed;
    reg  [10:0]        depthLim;
    wire               capEn;
    wire               cap;
    wire               full;
    wire               seqLive;
    wire               termHit;
    wire               rstHit;
    wire               cntHit;
    wire               advance;
    wire               fire;
    wire               mark;
    wire               store;
    wire [15:0]        cntField;

    // a background monitor stops capture; a foreground one does not
    assign capEn = running && !haltS_q && (fgMon || !monS_q);
    assign cap   = fifoVal && capEn;

    always @* begin
        depthLim = (cmode == `CMODE_OFF) ? `DEPTH_NOCNT
                                         : `DEPTH_CNT;
        nTerms = (nReq == 3'h0) ? 3'h1 : nReq;
        if (win && nTerms > `WIN_TERMS)
            nTerms = `WIN_TERMS;
        occNeed = occ_q[idx_q];
        if (win || occNeed == 16'h0000)
            occNeed = 16'h0001;
    end

    assign full     = (wrPtr_q >= depthLim);
    // until-halted never lets the sequencer run, so no trigger
    assign seqLive  = cap && !untilH && !triggered;
    assign termHit  = hit(fifoDat, pat_q[idx_q], mask_q[idx_q]);
    assign rstHit   = seqLive && !win &&
                      hit(fifoDat, pat_q[`SLOT_RST],
                          mask_q[`SLOT_RST]);
    assign advance  = seqLive && termHit && !rstHit &&
                      (occCnt_q + 16'h0001 >= occNeed);
    assign fire     = advance && (idx_q == nTerms - 3'h1);
    assign mark     = advance || rstHit;
    assign store    = cap && !full;
    assign cntHit   = cap && hit(fifoDat, pat_q[`SLOT_CNTQ],
                                 mask_q[`SLOT_CNTQ]);
    assign cntField = (cmode == `CMODE_TIME)  ? count_q :
                      (cmode == `CMODE_STATE) ? count_q + {15'h0000, cntHit}
                                              : 16'h0000;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            running   <= 1'b0;
            triggered <= 1'b0;
            breakReq  <= 1'b0;
            idx_q     <= 3'h0;
            occCnt_q  <= 16'h0000;
            count_q   <= 16'h0000;
            wrPtr_q   <= 11'h000;
        end else if (startP_q) begin
            running   <= 1'b1;
            triggered <= 1'b0;
            breakReq  <= 1'b0;
            idx_q     <= 3'h0;
            occCnt_q  <= 16'h0000;
            count_q   <= 16'h0000;
            wrPtr_q   <= 11'h000;
        end else begin
            if (stopP_q)
                running <= 1'b0;
            else if (triggered && full)
                running <= 1'b0;
            // count field is relative to the previous stored state
            if (store)
                count_q <= 16'h0000;
            else if (cmode == `CMODE_TIME && running &&
                     count_q != 16'hffff)
                count_q <= count_q + 16'h0001;
            else if (cmode == `CMODE_STATE && cntHit &&
                     count_q != 16'hffff)
                count_q <= count_q + 16'h0001;
            if (store)
                wrPtr_q <= wrPtr_q + 11'h001;
            if (rstHit) begin
                idx_q    <= 3'h0;
                occCnt_q <= 16'h0000;
            end else if (fire) begin
                triggered <= 1'b1;
                // the core sees the request a few cycles later
                if (brkOn)
                    breakReq <= 1'b1;
            end else if (advance) begin
                idx_q    <= idx_q + 3'h1;
                occCnt_q <= 16'h0000;
            end else if (seqLive && termHit) begin
                occCnt_q <= occCnt_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    state_fifo #(
        .WIDTH (STATE_W),
        .DEPTH (8),
        .AW    (3)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .inValid  (stateValid),
        .inData   (stateData),
        .inReady  (stateReady),
        .outValid (fifoVal),
        .outData  (fifoDat),
        .outReady (capEn)
    );

    trace_mem #(
        .WIDTH (MW),
        .AW    (10)
    ) u_mem (
        .clk_sys (clk_sys),
        .we      (store),
        .waddr   (wrPtr_q[9:0]),
        .wdata   ({mark, fire, cntField, fifoDat}),
        .raddr   (rdAddr_q),
        .rdata   (memOut)
    );

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    reg [31:0] rdMux;
    reg        rdOk;

    assign arready = !rvalid;

    always @* begin
        rdOk  = 1'b1;
        rdMux = 32'h0000_0000;
        case (araddr)
            `A_CTRL:   rdMux = ctrl_q;
            `A_STATUS: rdMux = {13'h0000, full, wrPtr_q, 1'b0,
                                idx_q, breakReq, triggered, running};
            `A_SEL:    rdMux = {28'h0000000, sel_q};
            `A_PAT:    rdMux = (sel_q <= `SLOT_CNTQ) ? pat_q[sel_q]
                                                     : 32'h0000_0000;
            `A_MASK:   rdMux = (sel_q <= `SLOT_CNTQ) ? mask_q[sel_q]
                                                     : 32'h0000_0000;
            `A_OCC:    rdMux = (sel_q < `SLOT_RST)
                               ? {16'h0000, occ_q[sel_q[2:0]]}
                               : 32'h0000_0000;
            `A_RDADDR: rdMux = {22'h000000, rdAddr_q};
            `A_RDDATA: rdMux = memOut[31:0];
            `A_RDINFO: rdMux = {14'h0000, memOut[MW-1:STATE_W]};
            default:   rdOk  = 1'b0;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rdMux;
            rresp  <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule // trace_trigger_sequencer

// ===== tb/seq_checker_assertions.sv
// port checker for the trace trigger sequencer
`timescale 1ns/1ps
`include "trace_seq_consts.vh"
module seq_checker (
    input wire        clk_sys,
    input wire        rstn,
    input wire        awvalid,
    input wire        awready,
    input wire        wvalid,
    input wire        wready,
    input wire [1:0]  bresp,
    input wire        bvalid,
    input wire        bready,
    input wire [7:0]  araddr,
    input wire        arvalid,
    input wire        arready,
    input wire [31:0] rdata,
    input wire [1:0]  rresp,
    input wire        rvalid,
    input wire        rready,
    input wire        breakReq,
    input wire        triggered,
    input wire        running
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ------------
    // register bus
    // ------------
    property p_bhold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bresp not held");
    property p_rhold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("rdata not held");
    property p_wblock;
        bvalid |-> !awready && !wready;
    endproperty
    a_wblock: assert property (p_wblock) else $error("write taken early");
    property p_wresp;
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
    endproperty
    a_wresp: assert property (p_wresp) else $error("write unanswered");
    property p_unmap;
        arvalid && arready && araddr == 8'h24 |=>
            rresp == `RESP_SLVERR && rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read ok");
    // ------------
    // sequencer
    // ------------
    property p_brk;
        breakReq |-> triggered;
    endproperty
    a_brk: assert property (p_brk) else $error("break w/o trigger");
    property p_trigclr;
        $fell(triggered) |-> $past(bvalid);
    endproperty
    a_trigclr: assert property (p_trigclr) else $error("bad clear");
    property p_trigrun;
        $rose(triggered) |-> $past(running);
    endproperty
    a_trigrun: assert property (p_trigrun) else $error("idle trig");
    c_trig: cover property ($rose(triggered));
    c_brk: cover property ($rose(breakReq));
    c_slverr: cover property (bvalid && bresp == `RESP_SLVERR);
endmodule // seq_checker

bind trace_trigger_sequencer seq_checker chk_u (.*);

// ===== tb/bus_state_source.sv
// bus-state source standing in for the emulated processor
`timescale 1ns/1ps
module bus_state_source (
    input  wire        clk_sys,
    input  wire        stateReady,
    output reg         stateValid,
    output reg  [31:0] stateData
);
    initial begin
        stateValid = 1'b0;
        stateData  = 32'h0;
    end
    // gap idles the source for a slow processor
    task automatic push(input [31:0] d, input int gap);
        begin
            repeat (gap + 1) @(posedge clk_sys);
            stateValid <= 1'b1;
            stateData  <= d;
            do @(posedge clk_sys); while (!stateReady);
            stateValid <= 1'b0;
            // idle bus shows no stale state
            stateData  <= ~d;
        end
    endtask
endmodule // bus_state_source

// ===== tb/tb_top.sv
// self-checking bench for the trace trigger sequencer
`timescale 1ns/1ps
`include "trace_seq_consts.vh"
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rstn, awvalid, wvalid, bready, arvalid, rready;
    logic        procHalted, inMonitor;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rv, dv;
    logic [1:0]  rr, br;
    wire         awready, wready, bvalid, arready, rvalid, stateValid;
    wire         stateReady, breakReq, triggered, running;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata, stateData;
    int          n_fail, n_tests, i, m, n;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] d;
        logic        w;
        logic [31:0] e;
        logic [1:0]  r;
    } row_t;
    row_t rows [6] = '{
        '{`A_CTRL, 32'h0, 1'b0, `CTRL_RESET, `RESP_OKAY},
        '{`A_OCC, 32'h0, 1'b0, {16'h0, `OCC_RESET}, `RESP_OKAY},
        '{`A_OCC, 32'hffff, 1'b1, 32'hffff, `RESP_OKAY},
        '{`A_SEL, 32'h8, 1'b1, 32'h8, `RESP_OKAY},
        '{8'h24, 32'h5, 1'b1, 32'h0, `RESP_SLVERR},
        '{`A_STATUS, 32'h0, 1'b0, 32'h0, `RESP_OKAY}};
    logic [31:0] seqB [5] = '{32'h100, 32'h55, 32'h100, 32'h101, 32'hdead};
    logic [31:0] seqD [4] = '{32'h100, 32'hdead, 32'h101, 32'h102};

    trace_trigger_sequencer dut_u (.clk_sys(clk_sys), .rstn(rstn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .stateValid(stateValid), .stateData(stateData),
        .stateReady(stateReady), .procHalted(procHalted),
        .inMonitor(inMonitor), .breakReq(breakReq),
        .triggered(triggered), .running(running));
    bus_state_source src_u (.clk_sys(clk_sys), .stateReady(stateReady),
        .stateValid(stateValid), .stateData(stateData));

    always #5 clk_sys = ~clk_sys;
    // ------------
    // bus tasks
    // ------------
    task automatic chk(input [31:0] s, input [31:0] e);
        n_tests++;
        if (s !== e) begin
            $display("Error t=%0t seen %h exp %h", $time, s, e);
            n_fail++;
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        br = bresp;
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic slot(input [3:0] s, input [31:0] p, mk, oc);
        wr(`A_SEL, {28'h0, s});
        wr(`A_PAT, p);
        wr(`A_MASK, mk);
        wr(`A_OCC, oc);
    endtask
    // entry data lands in dv, its info word in rv
    task automatic rdi(input [9:0] x);
        wr(`A_RDADDR, {22'h0, x});
        rd(`A_RDDATA);
        dv = rv;
        rd(`A_RDINFO);
    endtask
    task automatic stat;
        repeat (8) @(posedge clk_sys);
        rd(`A_STATUS);
    endtask
    task automatic end_of_test;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ------------
    // run
    // ------------
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        end_of_test;
    end
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {procHalted, inMonitor, awaddr, araddr, wdata} = 50'h0;
        {n_fail, n_tests} = 64'h0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[k]) begin
            if (rows[k].w) wr(rows[k].a, rows[k].d);
            if (rows[k].w) chk(32'(br), 32'(rows[k].r));
            rd(rows[k].a);
            chk(rv, rows[k].e);
            chk(32'(rr), 32'(rows[k].r));
        end
        // depth per count mode; until-halted, so nothing triggers
        slot(4'h8, 32'h0, 32'h1, 32'h1);
        for (m = 0; m < 3; m++) begin
            n = (m == 2) ? 1024 : 512;
            wr(`A_CTRL, 32'h111 | (m << 2));
            for (i = 0; i < n + 4; i++) src_u.push(i, 0);
            stat;
            chk(rv & 32'h7ffbf, 32'h40001 | (n << 7));
            if (m == 1) begin
                rdi(10'h4);
                chk(rv & 32'hffff, 32'h1);
                rdi(10'h5);
                chk(rv & 32'hffff, 32'h0);
            end
            wr(`A_CTRL, 32'h102);
        end
        // seven terms, occurrence two on the first, global restart
        for (i = 0; i < 7; i++) slot(i[3:0], 32'h100 + i, '1, 32'h1);
        slot(4'h0, 32'h100, '1, 32'h2);
        slot(4'h7, 32'hdead, '1, 32'h1);
        wr(`A_CTRL, 32'h721);
        foreach (seqB[k]) src_u.push(seqB[k], k % 2);
        stat;
        chk(rv & 32'h3f, 32'h1);
        src_u.push(32'h100, 3);
        stat;
        chk(rv & 32'h3f, 32'h1);
        for (i = 0; i < 6; i++) src_u.push(i ? 32'h100 + i : 32'h100, 0);
        stat;
        chk(rv & 32'h3f, 32'h31);
        src_u.push(32'h106, 0);
        stat;
        chk(rv & 32'h7, 32'h7);
        chk({29'h0, breakReq, triggered, running}, 32'h7);
        rdi(10'h1);
        chk(rv & 32'h20000, 32'h0);
        rdi(10'h2);
        chk(rv & 32'h20000, 32'h20000);
        rdi(10'h4);
        chk(rv & 32'h20000, 32'h20000);
        rdi(10'hc);
        chk(dv, 32'h106);
        chk(rv & 32'h10000, 32'h10000);
        wr(`A_CTRL, 32'h101);
        rd(`A_STATUS);
        chk(rv, 32'h1);
        // windowing: four terms, counts and restart ignored
        wr(`A_CTRL, 32'h741);
        foreach (seqD[k]) src_u.push(seqD[k], 0);
        stat;
        chk(rv & 32'h3f, 32'h19);
        src_u.push(32'h103, 0);
        stat;
        chk(rv & 32'h2, 32'h2);
        // monitor and halt gating of capture
        inMonitor <= 1'b1;
        wr(`A_CTRL, 32'h191);
        repeat (3) src_u.push(32'h1, 0);
        stat;
        chk(rv & 32'h3ff80, 32'h180);
        wr(`A_CTRL, 32'h111);
        // fill the fifo while capture is gated off
        repeat (8) src_u.push(32'h1, 0);
        stat;
        chk(rv & 32'h3ff80, 32'h0);
        chk({31'h0, stateReady}, 32'h0);
        inMonitor  <= 1'b0;
        procHalted <= 1'b1;
        stat;
        chk(rv & 32'h3ff80, 32'h0);
        procHalted <= 1'b0;
        repeat (8) @(posedge clk_sys);
        stat;
        chk(rv & 32'h3ff80, 32'h400);
        end_of_test;
    end
endmodule // tb_top
